// [sird_pkg.sv]
// shared opcodes, widths, host port offsets and bit positions for the ident/register command decoder
package sird_pkg;
	localparam logic [7:0] READ_IDENT_CMD = 8'h9F;
	localparam logic [7:0] READ_DISCOVERY_PARAMS_CMD = 8'h5A;
	localparam logic [7:0] READ_UNIQUE_SERIAL_CMD = 8'h4C;
	localparam logic [7:0] READ_STATUS_ONE_CMD = 8'h05;
	localparam logic [7:0] READ_STATUS_TWO_CMD = 8'h07;
	localparam logic [7:0] READ_ANY_REG_CMD = 8'h65;
	localparam logic [7:0] SET_WRITE_LATCH_CMD = 8'h06;
	localparam logic [7:0] CLEAR_WRITE_LATCH_CMD = 8'h04;
	localparam logic [7:0] WRITE_ANY_REG_CMD = 8'h71;
	localparam logic [7:0] ENTER_LONG_ADDR_CMD = 8'hB7;
	localparam logic [7:0] EXIT_LONG_ADDR_CMD = 8'hB8;
	localparam int DISCOVERY_ADDR_BYTES = 3;
	localparam int SHORT_ADDR_BYTES = 3;
	localparam int LONG_ADDR_BYTES = 4;
	localparam int UNIQUE_SERIAL_BITS = 64;
	localparam int WEL_BIT = 1;
	localparam int REG_ADDR_BITS = 8;
	localparam int HOST_DIV = 4;
	// host command port addresses
	localparam logic [3:0] H_CMD_OFS = 4'h0;
	localparam logic [3:0] H_ADDR_OFS = 4'h1;
	localparam logic [3:0] H_CTRL_OFS = 4'h2;
	localparam logic [3:0] H_STAT_OFS = 4'h3;
	localparam logic [3:0] H_RDAT_OFS = 4'h4;
	localparam logic [3:0] H_WDAT_OFS = 4'h5;
	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_LONG_BIT = 1;
	localparam int STAT_BUSY_BIT = 0;
	// host operation shapes
	localparam logic [1:0] ADDR_NONE = 2'h0;
	localparam logic [1:0] ADDR_THREE = 2'h1;
	localparam logic [1:0] ADDR_FOUR = 2'h2;
endpackage

// [sird_link_if.sv]
// single-lane spi link between controller and decoder
`timescale 1ns/1ps
`default_nettype none
interface sird_link_if;
	logic sclk;
	logic cs_n;
	logic mosi;
	logic serial_output_lane;
	logic serial_output_lane_oe;
	modport host (output sclk, output cs_n, output mosi, input serial_output_lane, input serial_output_lane_oe);
	modport dev (input sclk, input cs_n, input mosi, output serial_output_lane, output serial_output_lane_oe);
endinterface
`default_nettype wire

// [sird_shift_out.sv]
// msb-first byte shifter on falling sclk for the output lane
`timescale 1ns/1ps
`default_nettype none
module sird_shift_out (
	// link
	input wire logic sclk,
	input wire logic cs_n,
	// byte source
	input wire logic load,
	input wire logic [7:0] byte_in,
	// lane
	output logic lane,
	output logic lane_oe
);
	logic [7:0] sh_q;
	// launch on falling edge so the host samples stable data on rising
	always_ff @(negedge sclk or posedge cs_n) begin
		if (cs_n) begin
			sh_q <= 8'h00;
			lane_oe <= 1'b0;
		end else if (load) begin
			sh_q <= {byte_in[6:0], 1'b0};
			lane_oe <= 1'b1;
		end else begin
			sh_q <= {sh_q[6:0], 1'b0};
		end
	end
	always_ff @(negedge sclk or posedge cs_n) begin
		if (cs_n) begin
			lane <= 1'b0;
		end else if (load) begin
			lane <= byte_in[7];
		end else begin
			lane <= sh_q[7];
		end
	end
endmodule // sird_shift_out
`default_nettype wire

// [sird_device.sv]
// spi flash ident and register-access command decoder (device end)
// How it works
// RL1 - 9F returns ident bytes, no address
// RL2 - 5A, three address bytes, sequential table
// RL3 - 4C returns fixed 64-bit unique serial
// RL4 - 05 returns status register one
// RL5 - 07 returns status register two
// RL6 - 65 reads register at 3/4-byte address
// RL7 - 06 sets write enable latch
// RL8 - 04 clears write enable latch
// RL9 - latch clear blocks register writes
// RL10 - 71 address then byte writes register
// RL11 - B7/B8 select four or three address bytes
// RL12 - cs low frames, msb first, bit per clock
//
// The register offsets and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module sird_device import sird_pkg::*; #(
	parameter logic [7:0] MFR_ID = 8'h5C, // arbitrary
	parameter logic [7:0] DEV_ID0 = 8'h2A, // arbitrary
	parameter logic [7:0] DEV_ID1 = 8'h1B, // arbitrary
	parameter logic [63:0] UNIQUE_SERIAL = 64'h0123_4567_89AB_CDEF, // arbitrary
	parameter logic [7:0] STATUS_TWO = 8'h00
) (
	// system
	input wire logic ref_clk,
	input wire logic reset,
	// link
	sird_link_if.dev link,
	// user side, ref_clk domain
	output logic long_addr,
	output logic write_latch,
	output logic [7:0] reg_probe
);
	typedef enum logic [4:0] {
		S_OPC = 5'b00001,
		S_ADDR = 5'b00010,
		S_DATA = 5'b00100,
		S_OUT = 5'b01000,
		S_IDLE = 5'b10000
	} sird_dstate_t;

	sird_dstate_t st_q;
	logic [2:0] bit_q;
	logic [2:0] nbytes_q;
	logic [7:0] sh_q;
	logic [7:0] opc_q;
	logic [31:0] addr_q;
	logic [7:0] seq_q;
	logic wel_q;
	logic long_q;
	logic [7:0] regs_q [0:255];

	/////////////////////////////////////////////////////////////////
	// input side, sampled on rising sclk
	wire logic [7:0] rx_byte = {sh_q[6:0], link.mosi}; // RL12
	wire logic byte_done = bit_q == 3'd7;
	// opcode just completed on the input lane
	wire logic rx_ident = rx_byte == READ_IDENT_CMD;
	wire logic rx_disc = rx_byte == READ_DISCOVERY_PARAMS_CMD;
	wire logic rx_uid = rx_byte == READ_UNIQUE_SERIAL_CMD;
	wire logic rx_st1 = rx_byte == READ_STATUS_ONE_CMD;
	wire logic rx_st2 = rx_byte == READ_STATUS_TWO_CMD;
	wire logic rx_rdreg = rx_byte == READ_ANY_REG_CMD;
	wire logic rx_wrreg = rx_byte == WRITE_ANY_REG_CMD;
	wire logic rx_wren = rx_byte == SET_WRITE_LATCH_CMD;
	wire logic rx_wrdi = rx_byte == CLEAR_WRITE_LATCH_CMD;
	wire logic rx_long = rx_byte == ENTER_LONG_ADDR_CMD;
	wire logic rx_short = rx_byte == EXIT_LONG_ADDR_CMD;
	wire logic has_addr3 = rx_disc;
	wire logic has_addrv = rx_rdreg || rx_wrreg;
	wire logic is_out0 = rx_ident || rx_uid || rx_st1 || rx_st2;
	// opcode held for the rest of the frame
	wire logic op_ident = opc_q == READ_IDENT_CMD;
	wire logic op_uid = opc_q == READ_UNIQUE_SERIAL_CMD;
	wire logic op_st1 = opc_q == READ_STATUS_ONE_CMD;
	wire logic op_st2 = opc_q == READ_STATUS_TWO_CMD;
	wire logic op_disc = opc_q == READ_DISCOVERY_PARAMS_CMD;
	wire logic op_wrreg = opc_q == WRITE_ANY_REG_CMD;
	wire logic [2:0] addr_len = long_q ? 3'(LONG_ADDR_BYTES) : 3'(SHORT_ADDR_BYTES); // RL11
	wire logic [7:0] reg_idx = addr_q[7:0];
	wire logic [7:0] status_one = 8'(wel_q) << WEL_BIT; // RL4 RL7

	always_ff @(posedge link.sclk or posedge link.cs_n) begin
		if (link.cs_n) begin
			st_q <= S_OPC; // RL12
			bit_q <= 3'd0;
			sh_q <= 8'h00;
		end else begin
			bit_q <= bit_q + 3'd1;
			sh_q <= rx_byte;
			if (byte_done) begin
				unique case (st_q)
					S_OPC: begin
						if (has_addr3 || has_addrv) st_q <= S_ADDR;
						else if (is_out0) st_q <= S_OUT;
						else st_q <= S_IDLE;
					end
					S_ADDR: if (nbytes_q == 3'd1) st_q <= op_wrreg ? S_DATA : S_OUT;
					S_DATA: st_q <= S_IDLE;
					S_OUT: st_q <= S_OUT;
					S_IDLE: st_q <= S_IDLE;
				endcase
			end
		end
	end

	// opcode, address count and transaction bookkeeping
	always_ff @(posedge link.sclk) begin
		if (!link.cs_n && byte_done && st_q == S_OPC) begin
			opc_q <= rx_byte;
			addr_q <= 32'h0;
			nbytes_q <= has_addr3 ? 3'(DISCOVERY_ADDR_BYTES) : addr_len; // RL2 RL6 RL10
		end else if (!link.cs_n && byte_done && st_q == S_ADDR) begin
			addr_q <= {addr_q[23:0], rx_byte}; // RL2 RL6
			nbytes_q <= nbytes_q - 3'd1;
		end
	end

	// latch and address mode live in the link domain; sclk stands still outside frames,
	// so reset asserts at once and only its release waits for two rising sclk edges
	logic rst_s1;
	logic rst_s2;
	always_ff @(posedge link.sclk or posedge reset) begin
		if (reset) begin
			rst_s1 <= 1'b1;
			rst_s2 <= 1'b1;
		end else begin
			rst_s1 <= 1'b0;
			rst_s2 <= rst_s1;
		end
	end
	wire logic opc_done = !link.cs_n && byte_done && st_q == S_OPC;
	wire logic wr_done = !link.cs_n && byte_done && st_q == S_DATA;
	always_ff @(posedge link.sclk or posedge rst_s2) begin
		if (rst_s2) begin
			wel_q <= 1'b0;
			long_q <= 1'b0;
		end else if (opc_done) begin
			if (rx_wren) wel_q <= 1'b1; // RL7
			if (rx_wrdi) wel_q <= 1'b0; // RL8
			if (rx_long) long_q <= 1'b1; // RL11
			if (rx_short) long_q <= 1'b0; // RL11
		end else if (wr_done && wel_q) begin
			wel_q <= 1'b0; // latch self-clears after a completed write
		end
	end
	always_ff @(posedge link.sclk) begin
		if (wr_done && wel_q) regs_q[reg_idx] <= rx_byte; // RL9 RL10
	end

	/////////////////////////////////////////////////////////////////
	// output side
	wire logic [2:0] seq_b = seq_q[2:0];
	wire logic [7:0] ident_byte = seq_q == 8'd0 ? MFR_ID : seq_q == 8'd1 ? DEV_ID0 : DEV_ID1; // RL1
	wire logic [7:0] uid_byte = UNIQUE_SERIAL[8'(63 - 8 * int'(seq_b)) -: 8]; // RL3
	wire logic [7:0] disc_byte = addr_q[7:0] + seq_q; // RL2
	wire logic [7:0] out_byte =
		op_ident ? ident_byte :
		op_uid ? uid_byte :
		op_st1 ? status_one : // RL4
		op_st2 ? STATUS_TWO : // RL5
		op_disc ? disc_byte :
		regs_q[reg_idx]; // RL6
	logic load_q;
	// load flag from rising edge, consumed at next falling edge
	always_ff @(posedge link.sclk or posedge link.cs_n) begin
		if (link.cs_n) begin
			load_q <= 1'b0;
			seq_q <= 8'h00;
		end else begin
			load_q <= byte_done && (st_q == S_OUT || (st_q == S_OPC && is_out0)
				|| (st_q == S_ADDR && nbytes_q == 3'd1 && !op_wrreg));
			if (byte_done && st_q == S_OUT) seq_q <= seq_q + 8'd1;
		end
	end
	sird_shift_out u_out (
		.sclk(link.sclk),
		.cs_n(link.cs_n),
		.load(load_q),
		.byte_in(out_byte),
		.lane(link.serial_output_lane),
		.lane_oe(link.serial_output_lane_oe)
	);

	/////////////////////////////////////////////////////////////////
	// status levels into ref_clk domain
	logic long_s1, long_s2, wel_s1, wel_s2;
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			long_s1 <= 1'b0;
			long_s2 <= 1'b0;
			wel_s1 <= 1'b0;
			wel_s2 <= 1'b0;
			long_addr <= 1'b0;
			write_latch <= 1'b0;
			reg_probe <= 8'h00;
		end else begin
			long_s1 <= long_q;
			long_s2 <= long_s1;
			wel_s1 <= wel_q;
			wel_s2 <= wel_s1;
			long_addr <= long_s2;
			write_latch <= wel_s2;
			reg_probe <= {6'h00, wel_s2, long_s2};
		end
	end
endmodule // sird_device
`default_nettype wire

// [sird_host.sv]
// spi host controller: runs one single-lane transaction from software registers
`timescale 1ns/1ps
`default_nettype none
module sird_host import sird_pkg::*; #(
	parameter int MAX_RX = 8
) (
	// system
	input wire logic ref_clk,
	input wire logic reset,
	// software port
	input wire logic [3:0] sw_addr,
	input wire logic [31:0] sw_wdata,
	input wire logic sw_wr,
	input wire logic sw_rd,
	output logic [31:0] sw_rdata,
	// link
	sird_link_if.host link
);
	typedef enum logic [2:0] {
		H_IDLE = 3'b001,
		H_SHIFT = 3'b010,
		H_END = 3'b100
	} sird_hstate_t;
	sird_hstate_t st_q;
	logic [7:0] cmd_q, wdat_q;
	logic [31:0] addr_q;
	logic [3:0] ctrl_q;
	logic [7:0] nbits_q; // total bits in transaction
	logic [7:0] cnt_q;
	logic [1:0] div_q;
	logic [63:0] tx_q, rx_q;
	logic miso_s1, miso_s2;

	wire logic wr_cmd = sw_wr && sw_addr == H_CMD_OFS;
	wire logic wr_addr = sw_wr && sw_addr == H_ADDR_OFS;
	wire logic wr_wdat = sw_wr && sw_addr == H_WDAT_OFS;
	wire logic go = sw_wr && sw_addr == H_CTRL_OFS && sw_wdata[CTRL_START_BIT] && st_q == H_IDLE;
	wire logic [1:0] shape = sw_wdata[3:2];
	wire logic [3:0] rx_bytes = sw_wdata[7:4];
	// frame: cmd, optional address, optional write byte (sent only after an address), then rx bytes clocked
	wire logic [7:0] abits = shape == ADDR_THREE ? 8'd24 : shape == ADDR_FOUR ? 8'd32 : 8'd0;
	wire logic [7:0] dbits = sw_wdata[8] ? 8'd8 : 8'd0;
	wire logic [63:0] frame = shape == ADDR_FOUR ? {cmd_q, addr_q, wdat_q, 16'h0000} :
		shape == ADDR_THREE ? {cmd_q, addr_q[23:0], wdat_q, 24'h000000} : {cmd_q, 56'h0};
	wire logic edge_fall = div_q == 2'(HOST_DIV - 1);
	wire logic edge_rise = div_q == 2'(HOST_DIV / 2 - 1);
	// lane sample waits a cycle past the rise so it clears the two-stage synchroniser
	wire logic edge_mid = div_q == 2'(HOST_DIV / 2);

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			cmd_q <= 8'h00;
			addr_q <= 32'h0;
			wdat_q <= 8'h00;
			ctrl_q <= 4'h0;
		end else begin
			if (wr_cmd) cmd_q <= sw_wdata[7:0];
			if (wr_addr) addr_q <= sw_wdata;
			if (wr_wdat) wdat_q <= sw_wdata[7:0];
			if (go) ctrl_q <= sw_wdata[3:0];
		end
	end

	// derived sclk: ref_clk / HOST_DIV, mode 0, msb first
	always_ff @(posedge ref_clk) begin
		miso_s1 <= link.serial_output_lane;
		miso_s2 <= miso_s1;
		if (reset) begin
			st_q <= H_IDLE;
			link.cs_n <= 1'b1;
			link.sclk <= 1'b0;
			link.mosi <= 1'b0;
			div_q <= 2'd0;
			cnt_q <= 8'd0;
			nbits_q <= 8'd0;
			tx_q <= 64'h0;
			rx_q <= 64'h0;
		end else begin
			unique case (st_q)
				H_IDLE: if (go) begin
					st_q <= H_SHIFT;
					link.cs_n <= 1'b0;
					link.mosi <= frame[63];
					tx_q <= {frame[62:0], 1'b0};
					nbits_q <= 8'd8 + abits + dbits + {1'b0, rx_bytes, 3'b000};
					cnt_q <= 8'd0;
					div_q <= 2'd0;
					rx_q <= 64'h0;
				end
				H_SHIFT: begin
					div_q <= div_q + 2'd1;
					if (edge_rise) begin
						link.sclk <= 1'b1;
						cnt_q <= cnt_q + 8'd1;
					end
					if (edge_mid) rx_q <= {rx_q[62:0], miso_s2}; // RL12
					if (edge_fall) begin
						link.sclk <= 1'b0;
						if (cnt_q == nbits_q) st_q <= H_END;
						else begin
							link.mosi <= tx_q[63];
							tx_q <= {tx_q[62:0], 1'b0};
						end
					end
				end
				H_END: begin
					link.cs_n <= 1'b1;
					st_q <= H_IDLE;
				end
			endcase
		end
	end

	wire logic [31:0] rd_mux = sw_addr == H_CMD_OFS ? {24'h0, cmd_q} :
		sw_addr == H_ADDR_OFS ? addr_q :
		sw_addr == H_CTRL_OFS ? {28'h0, ctrl_q} :
		sw_addr == H_STAT_OFS ? {31'h0, st_q != H_IDLE} :
		sw_addr == H_RDAT_OFS ? rx_q[31:0] :
		sw_addr == H_WDAT_OFS ? {24'h0, wdat_q} : 32'h0;
	always_ff @(posedge ref_clk) begin
		if (reset) sw_rdata <= 32'h0;
		else if (sw_rd) sw_rdata <= rd_mux;
		else sw_rdata <= 32'h0;
	end
endmodule // sird_host
`default_nettype wire

// [sird_link_sva.sv]
// link-side checks for the ident/register command decoder
`timescale 1ns/1ps
`default_nettype none
module sird_link_sva (
	// system
	input wire logic ref_clk,
	input wire logic reset,
	// link
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic mosi,
	input wire logic serial_output_lane,
	input wire logic serial_output_lane_oe
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	logic sclk_q;
	logic [7:0] rise_q;
	wire logic sclk_rise = sclk && !sclk_q;
	// counter clears outside frames, so no reset is needed
	always_ff @(posedge ref_clk) begin
		sclk_q <= sclk;
		rise_q <= cs_n ? 8'h00 : rise_q + {7'h00, sclk_rise};
	end
	////////////////////////////////////////
	sequence idle_s;
		cs_n [*2];
	endsequence
	sequence high_s;
		sclk ##1 !sclk;
	endsequence
	idle_clk_a: assert property (idle_s |-> !sclk)
		else $error("serial clock moved outside a frame");
	idle_quiet_a: assert property (idle_s |-> !serial_output_lane_oe)
		else $error("output lane driven outside a frame");
	frame_bytes_a: assert property ($rose(cs_n) |-> rise_q[2:0] == 3'h0)
		else $error("frame not a whole number of bytes");
	rise_framed_a: assert property ($rose(sclk) |-> !cs_n)
		else $error("serial clock rose outside a frame");
	start_low_a: assert property ($fell(cs_n) |-> !sclk)
		else $error("frame opened with clock high");
	half_period_a: assert property ($rose(sclk) |-> ##1 high_s)
		else $error("serial clock high phase wrong");
	mosi_hold_a: assert property (!cs_n && $changed(mosi) |-> !sclk)
		else $error("input lane changed while clock high");
	lane_hold_a: assert property (serial_output_lane_oe && $changed(serial_output_lane) |-> !sclk)
		else $error("output lane changed while clock high");
	opcode_quiet_a: assert property (!cs_n && rise_q < 8'h08 |-> !serial_output_lane_oe)
		else $error("output lane driven during opcode");
endmodule // sird_link_sva
`default_nettype wire

// [spi_ident_register_cmd_decoder_tb.sv]
// bench joining host controller and decoder over the link
`timescale 1ns/1ps
`default_nettype none
module spi_ident_register_cmd_decoder_tb import sird_pkg::*;;
	localparam logic [7:0] MFR = 8'h5C; // arbitrary
	localparam logic [7:0] DEV0 = 8'h2A; // arbitrary
	localparam logic [7:0] DEV1 = 8'h1B; // arbitrary
	localparam logic [63:0] SERIAL = 64'hF0E1_D2C3_B4A5_9687; // arbitrary
	localparam logic [7:0] STAT2 = 8'h3C;
	localparam logic [31:0] WEL = 32'h1 << WEL_BIT;
	typedef struct {logic [7:0] cmd; logic [31:0] addr; logic [1:0] sh; logic [3:0] rx; logic [7:0] wd;
		logic [31:0] exp; logic [31:0] mask; logic wl; logic la;} sird_row_t;
	logic ref_clk = 1'b0;
	// raised at time zero so the link-side reset sees a rising edge
	logic reset = 1'b0;
	logic [3:0] sw_addr = 4'h0;
	logic [31:0] sw_wdata = 32'h0;
	logic sw_wr = 1'b0;
	logic sw_rd = 1'b0;
	logic [31:0] sw_rdata;
	logic long_addr;
	logic write_latch;
	logic [7:0] reg_probe;
	logic [31:0] d;
	int miscompares = 0;
	int num_checks = 0;
	sird_row_t rows [20];
	sird_link_if link ();
	always #5 ref_clk = ~ref_clk;
	sird_host sird_host_inst (.ref_clk(ref_clk), .reset(reset), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
		.sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .link(link));
	sird_device #(.MFR_ID(MFR), .DEV_ID0(DEV0), .DEV_ID1(DEV1), .UNIQUE_SERIAL(SERIAL), .STATUS_TWO(STAT2))
		sird_device_inst (.ref_clk(ref_clk), .reset(reset), .link(link), .long_addr(long_addr),
		.write_latch(write_latch), .reg_probe(reg_probe));
	sird_link_sva sird_link_sva_inst (.ref_clk(ref_clk), .reset(reset), .sclk(link.sclk), .cs_n(link.cs_n),
		.mosi(link.mosi), .serial_output_lane(link.serial_output_lane),
		.serial_output_lane_oe(link.serial_output_lane_oe));
	////////////////////////////////////////
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// leading edge wait leaves a gap so a strobe is never assigned twice
	task automatic sw_write(input logic [3:0] a, input logic [31:0] v);
		@(posedge ref_clk);
		sw_addr <= a;
		sw_wdata <= v;
		sw_wr <= 1'b1;
		@(posedge ref_clk);
		sw_wr <= 1'b0;
	endtask
	task automatic sw_read(input logic [3:0] a, output logic [31:0] v);
		@(posedge ref_clk);
		sw_addr <= a;
		sw_rd <= 1'b1;
		@(posedge ref_clk);
		sw_rd <= 1'b0;
		#1;
		v = sw_rdata;
	endtask
	task automatic run_row(input sird_row_t r);
		logic [31:0] v;
		int n;
		sw_write(H_CMD_OFS, {24'h0, r.cmd});
		sw_write(H_ADDR_OFS, r.addr);
		sw_write(H_WDAT_OFS, {24'h0, r.wd});
		sw_write(H_CTRL_OFS, {23'h0, r.cmd == WRITE_ANY_REG_CMD, r.rx, r.sh, 2'h1});
		v = 32'h1;
		n = 0;
		while (v[STAT_BUSY_BIT] !== 1'b0 && n < 400) begin
			sw_read(H_STAT_OFS, v);
			n++;
		end
		if (v[STAT_BUSY_BIT] !== 1'b0) begin
			miscompares++;
			print_verdict();
		end else begin
			// latch and mode cross from the link domain, allow the synchroniser time
			n = 0;
			while ((write_latch !== r.wl || long_addr !== r.la) && n < 16) begin
				@(posedge ref_clk);
				n++;
			end
			sw_read(H_RDAT_OFS, v);
			if (r.mask != 32'h0) check(v & r.mask, r.exp);
			check({write_latch, long_addr}, {r.wl, r.la});
			check(reg_probe, {6'h00, r.wl, r.la});
		end
	endtask
	////////////////////////////////////////
	initial begin
		reset <= 1'b1;
		rows = '{
			'{8'h9F, 0, 0, 4, 0, {MFR, DEV0, DEV1, DEV1}, '1, 0, 0},
			'{8'h5A, 'h10, 1, 4, 0, 'h10111213, '1, 0, 0},
			'{8'h4C, 0, 0, 8, 0, SERIAL[31:0], '1, 0, 0},
			'{8'h4C, 0, 0, 4, 0, SERIAL[63:32], '1, 0, 0},
			'{8'h07, 0, 0, 1, 0, STAT2, 'hFF, 0, 0},
			'{8'h06, 0, 0, 0, 0, 0, 0, 1, 0},
			'{8'h05, 0, 0, 1, 0, WEL, WEL, 1, 0},
			'{8'h71, 'h42, 1, 0, 'h5A, 0, 0, 0, 0},
			'{8'h65, 'h42, 1, 1, 0, 'h5A, 'hFF, 0, 0},
			'{8'h71, 'h42, 1, 0, 'hA5, 0, 0, 0, 0},
			'{8'h65, 'h42, 1, 1, 0, 'h5A, 'hFF, 0, 0},
			'{8'hB7, 0, 0, 0, 0, 0, 0, 0, 1},
			'{8'h06, 0, 0, 0, 0, 0, 0, 1, 1},
			'{8'h71, 'h43, 2, 0, 'hC3, 0, 0, 0, 1},
			'{8'h65, 'h43, 2, 1, 0, 'hC3, 'hFF, 0, 1},
			'{8'h06, 0, 0, 0, 0, 0, 0, 1, 1},
			'{8'h04, 0, 0, 0, 0, 0, 0, 0, 1},
			'{8'h05, 0, 0, 1, 0, 0, WEL, 0, 1},
			'{8'hB8, 0, 0, 0, 0, 0, 0, 0, 0},
			'{8'h65, 'h43, 1, 1, 0, 'hC3, 'hFF, 0, 0}
		};
		repeat (8) @(posedge ref_clk);
		reset <= 1'b0;
		@(posedge ref_clk);
		#1;
		check(link.cs_n, 1'b1);
		check(link.sclk, 1'b0);
		sw_read(4'hF, d);
		check(d, 32'h0);
		for (int i = 0; i < 20; i++) begin
			run_row(rows[i]);
		end
		// reset in mid-run must drop the long address mode again
		run_row('{8'hB7, 0, 0, 0, 0, 0, 0, 0, 1});
		@(posedge ref_clk);
		reset <= 1'b1;
		repeat (8) @(posedge ref_clk);
		reset <= 1'b0;
		run_row('{8'h05, 0, 0, 1, 0, 0, WEL, 0, 0});
		print_verdict();
	end
endmodule // spi_ident_register_cmd_decoder_tb
`default_nettype wire
